// file: include/lsr_pkg.sv
// package: constants, types and register map of the logic, shift and rotate unit
package lsr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_OPCODE  = 8'h04;
  localparam logic [7:0] OFS_OPERAND = 8'h08;
  localparam logic [7:0] OFS_SOURCE  = 8'h0C;
  localparam logic [7:0] OFS_COUNT   = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_RESULT  = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT   = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_DONE_BIT    = 1;
  localparam int STAT_ILLEGAL_BIT = 2;
  localparam int STAT_MEMWB_BIT   = 3;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  // ----------------------------------------------------------------
  // opcode patterns (first byte without the width bit)
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_IMM_LOGIC = 7'h40;  // 1000000W
  localparam logic [6:0] OPC_SHIFT_ONE = 7'h68;  // 1101000W
  localparam logic [6:0] OPC_SHIFT_CNT = 7'h69;  // 1101001W
  localparam logic [6:0] OPC_SHIFT_IMM = 7'h60;  // 1100000W
  localparam logic [6:0] OPC_AND_ACC   = 7'h12;  // 0010010W
  localparam logic [6:0] OPC_OR_ACC    = 7'h06;  // 0000110W
  localparam logic [6:0] OPC_XOR_ACC   = 7'h1A;  // 0011010W
  localparam logic [1:0] MOD_REG       = 2'b11;

  // ----------------------------------------------------------------
  // timing counts in clock cycles
  // ----------------------------------------------------------------
  localparam logic [8:0] CYC_LOGIC_RR   = 9'h005;
  localparam logic [8:0] CYC_LOGIC_RM   = 9'h006;
  localparam logic [8:0] CYC_LOGIC_MR   = 9'h007;
  localparam logic [8:0] CYC_LOGIC_MI   = 9'h007;
  localparam logic [8:0] CYC_SHIFT1_REG = 9'h006;
  localparam logic [8:0] CYC_SHIFT1_MEM = 9'h008;
  localparam logic [8:0] CYC_SHIFTN_REG = 9'h005;
  localparam logic [8:0] CYC_SHIFTN_MEM = 9'h007;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ROL  = 3'b000, OP_ROR  = 3'b001, OP_ROTATE_LEFT_THROUGH_CARRY_OP = 3'b010, OP_ROTATE_RIGHT_THROUGH_CARRY_OP = 3'b011,
    OP_SHL  = 3'b100, OP_SHR  = 3'b101, OP_BAD  = 3'b110, OP_ARITH_RIGHT_SHIFT_OP = 3'b111
  } shift_sel_t;

  typedef enum logic [2:0] {
    LG_OR = 3'b001, LG_AND = 3'b100, LG_XOR = 3'b110
  } logic_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } state_t;

  typedef struct packed {
    logic ovf;
    logic zero;
    logic sign;
    logic parity;
    logic aux;
    logic carry;
  } flags_t;

  localparam flags_t RST_FLAGS = 6'h00;

endpackage

// file: core/logic_shift_rotate_unit.sv
// logic, shift and rotate execution unit with an apb register port
//
// Operation
// - acc immediate forms: byte or word, 5 cycles
// - logical ops clear carry, overflow; set P,S,Z
// - memory immediate logical writes back, 7 cycles
// - 1000000W prefix, middle bits select op
// - count source from first opcode byte
// - repeat step while count nonzero, decrementing
// - single left shift: top into carry
// - counted left shift: 5+n or 7+n
// - single logical right shift, zero fill
// - counted logical right shift, overflow untouched
// - single arithmetic right shift clears overflow
// - counted arithmetic shift keeps top bit
// - left rotate copies top into carry, bottom
// - single right rotate: bottom into carry, top
// - counted right rotate repeats the step
// - single left rotate through carry
// - counted left rotate through carry
// - single right rotate through carry
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module logic_shift_rotate_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             op_done
);
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [31:0]     prdata_ff;
  logic            pready_ff;
  logic            pslverr_ff;
  logic [31:0]     nxt_prdata;
  logic            addr_hit;
  logic            wr_en;
  logic            start_req;
  logic [15:0]     opcode_ff;
  logic [7:0]      imm_cnt_ff;
  logic [15:0]     operand_ff;
  logic [15:0]     source_ff;
  logic [7:0]      count_low_register_ff;
  lsr_pkg::flags_t flags_ff;
  logic [15:0]     result_ff;
  logic            done_ff;
  logic            illegal_ff;
  logic            memwb_ff;
  logic            op_done_ff;
  lsr_pkg::state_t state_ff;
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign op_done = op_done_ff;
  assign wr_en     = psel & penable & pready_ff & pwrite & addr_hit;
  assign start_req = wr_en & (paddr == lsr_pkg::OFS_CTRL) & pwdata[lsr_pkg::CTRL_START_BIT];
  always_comb begin
    addr_hit   = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      lsr_pkg::OFS_CTRL:    nxt_prdata = 32'h0000_0000;
      lsr_pkg::OFS_OPCODE:  nxt_prdata = {8'h00, imm_cnt_ff, opcode_ff};
      lsr_pkg::OFS_OPERAND: nxt_prdata = {16'h0000, operand_ff};
      lsr_pkg::OFS_SOURCE:  nxt_prdata = {16'h0000, source_ff};
      lsr_pkg::OFS_COUNT:   nxt_prdata = {24'h00_0000, count_low_register_ff};
      lsr_pkg::OFS_FLAGS:   nxt_prdata = {26'h000_0000, flags_ff};
      lsr_pkg::OFS_RESULT:  nxt_prdata = {16'h0000, result_ff};
      lsr_pkg::OFS_STATUS:  nxt_prdata = {28'h000_0000, memwb_ff, illegal_ff, done_ff,
                                          state_ff == lsr_pkg::ST_RUN};
      default: begin
        addr_hit   = 1'b0;
        nxt_prdata = 32'h0000_0000;
      end
    endcase
  end
  // one wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      prdata_ff  <= (psel & penable & ~pready_ff & ~pwrite) ? nxt_prdata : 32'h0000_0000;
      pslverr_ff <= psel & penable & ~pready_ff & ~addr_hit;
    end
  end
  // software operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_ff             <= lsr_pkg::RST_WORD;
      imm_cnt_ff            <= lsr_pkg::RST_BYTE;
      operand_ff            <= lsr_pkg::RST_WORD;
      source_ff             <= lsr_pkg::RST_WORD;
      count_low_register_ff <= lsr_pkg::RST_BYTE;
    end else if (wr_en && state_ff == lsr_pkg::ST_IDLE) begin
      if (paddr == lsr_pkg::OFS_OPCODE) begin
        opcode_ff  <= pwdata[15:0];
        imm_cnt_ff <= pwdata[23:16];
      end
      if (paddr == lsr_pkg::OFS_OPERAND) operand_ff <= pwdata[15:0];
      if (paddr == lsr_pkg::OFS_SOURCE) source_ff <= pwdata[15:0];
      if (paddr == lsr_pkg::OFS_COUNT) count_low_register_ff <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [6:0]  opc_hi;
  logic        wide;
  logic [1:0]  mod_f;
  logic [2:0]  mid_f;
  logic        is_mem;
  logic        dec_logic;
  logic        dec_shift;
  logic        dec_acc;
  logic        dec_memdst;
  logic        dec_single;
  logic [7:0]  dec_count;
  logic [8:0]  dec_target;
  logic [2:0]  dec_lop;
  logic [15:0] dec_src;
  assign opc_hi = opcode_ff[7:1];
  assign wide   = opcode_ff[0];
  assign mod_f  = opcode_ff[15:14];
  assign mid_f  = opcode_ff[13:11];
  assign is_mem = (mod_f != lsr_pkg::MOD_REG);
  always_comb begin
    dec_logic  = 1'b0;
    dec_shift  = 1'b0;
    dec_acc    = 1'b0;
    dec_memdst = 1'b0;
    dec_single = 1'b0;
    dec_count  = 8'h00;
    dec_target = lsr_pkg::CYC_LOGIC_RR;
    dec_lop    = mid_f;
    dec_src    = source_ff;
    if (opc_hi == lsr_pkg::OPC_IMM_LOGIC) begin
      dec_logic  = (mid_f == lsr_pkg::LG_AND) | (mid_f == lsr_pkg::LG_OR) |
                   (mid_f == lsr_pkg::LG_XOR);
      dec_memdst = is_mem;
      dec_target = is_mem ? lsr_pkg::CYC_LOGIC_MI : lsr_pkg::CYC_LOGIC_RR;
      dec_src    = wide ? source_ff : {8'h00, source_ff[7:0]};
    end else if (opc_hi == lsr_pkg::OPC_AND_ACC || opc_hi == lsr_pkg::OPC_OR_ACC ||
                 opc_hi == lsr_pkg::OPC_XOR_ACC) begin
      dec_logic  = 1'b1;
      dec_acc    = 1'b1;
      dec_lop    = (opc_hi == lsr_pkg::OPC_AND_ACC) ? lsr_pkg::LG_AND :
                   (opc_hi == lsr_pkg::OPC_OR_ACC)  ? lsr_pkg::LG_OR : lsr_pkg::LG_XOR;
      dec_target = lsr_pkg::CYC_LOGIC_RR;
      dec_src    = wide ? source_ff : {8'h00, source_ff[7:0]};
    end else if (opcode_ff[7:6] == 2'b00 && opcode_ff[2] == 1'b0 &&
                 (opcode_ff[5:3] == lsr_pkg::LG_AND || opcode_ff[5:3] == lsr_pkg::LG_OR ||
                  opcode_ff[5:3] == lsr_pkg::LG_XOR)) begin
      dec_logic  = 1'b1;
      dec_lop    = opcode_ff[5:3];
      dec_memdst = is_mem & ~opcode_ff[1];
      dec_target = !is_mem ? lsr_pkg::CYC_LOGIC_RR :
                   opcode_ff[1] ? lsr_pkg::CYC_LOGIC_RM : lsr_pkg::CYC_LOGIC_MR;
    end else if (opc_hi == lsr_pkg::OPC_SHIFT_ONE || opc_hi == lsr_pkg::OPC_SHIFT_CNT ||
                 opc_hi == lsr_pkg::OPC_SHIFT_IMM) begin
      dec_shift  = (mid_f != lsr_pkg::OP_BAD);
      dec_memdst = is_mem;
      dec_single = (opc_hi == lsr_pkg::OPC_SHIFT_ONE);
      dec_count  = dec_single ? 8'h01 :
                   (opc_hi == lsr_pkg::OPC_SHIFT_CNT) ? count_low_register_ff : imm_cnt_ff;
      if (dec_single) begin
        dec_target = is_mem ? lsr_pkg::CYC_SHIFT1_MEM : lsr_pkg::CYC_SHIFT1_REG;
      end else begin
        dec_target = (is_mem ? lsr_pkg::CYC_SHIFTN_MEM : lsr_pkg::CYC_SHIFTN_REG) +
                     {1'b0, dec_count};
      end
    end
  end
  logic [15:0] logic_res;
  always_comb begin
    case (dec_lop)
      lsr_pkg::LG_AND: logic_res = operand_ff & dec_src;
      lsr_pkg::LG_OR:  logic_res = operand_ff | dec_src;
      default:         logic_res = operand_ff ^ dec_src;
    endcase
  end

  // ----------------------------------------------------------------
  // execution state
  // ----------------------------------------------------------------
  logic [8:0]  cnt_ff;
  logic [8:0]  target_ff;
  logic [7:0]  temp_ff;
  logic [15:0] work_ff;
  logic        cy_ff;
  logic        kind_logic_ff;
  logic        single_ff;
  logic        zero_cnt_ff;
  logic        wide_ff;
  logic [2:0]  op_ff;
  logic [7:0]  hi_keep_ff;
  logic        memdst_ff;
  logic        complete;
  assign complete = (state_ff == lsr_pkg::ST_RUN) && (cnt_ff == target_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= lsr_pkg::ST_IDLE;
      cnt_ff   <= 9'h000;
    end else begin
      case (state_ff)
        lsr_pkg::ST_IDLE: begin
          if (start_req && (dec_logic || dec_shift)) begin
            state_ff <= lsr_pkg::ST_RUN;
            cnt_ff   <= 9'h001;
          end
        end
        lsr_pkg::ST_RUN: begin
          if (complete) begin
            state_ff <= lsr_pkg::ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 9'h001;
          end
        end
        default: state_ff <= lsr_pkg::ST_IDLE;
      endcase
    end
  end

  // single-bit step
  logic [15:0] ls;
  logic [15:0] rs;
  logic [15:0] top_mask;
  logic [15:0] nxt_work;
  logic        nxt_cy;
  logic        msb;
  always_comb begin
    msb      = wide_ff ? work_ff[15] : work_ff[7];
    ls       = wide_ff ? {work_ff[14:0], 1'b0} : {8'h00, work_ff[6:0], 1'b0};
    rs       = wide_ff ? {1'b0, work_ff[15:1]} : {9'h000, work_ff[7:1]};
    top_mask = wide_ff ? 16'h8000 : 16'h0080;
    nxt_cy   = op_ff[0] ? work_ff[0] : msb;
    case (op_ff)
      lsr_pkg::OP_SHL:  nxt_work = ls;
      lsr_pkg::OP_SHR:  nxt_work = rs;
      lsr_pkg::OP_ARITH_RIGHT_SHIFT_OP: nxt_work = rs | (msb ? top_mask : 16'h0000);
      lsr_pkg::OP_ROL:  nxt_work = {ls[15:1], msb};
      lsr_pkg::OP_ROR:  nxt_work = rs | (work_ff[0] ? top_mask : 16'h0000);
      lsr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_OP: nxt_work = {ls[15:1], cy_ff};
      lsr_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP: nxt_work = rs | (cy_ff ? top_mask : 16'h0000);
      default:          nxt_work = work_ff;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_ff       <= lsr_pkg::RST_WORD;
      temp_ff       <= 8'h00;
      cy_ff         <= 1'b0;
      target_ff     <= 9'h000;
      kind_logic_ff <= 1'b0;
      single_ff     <= 1'b0;
      zero_cnt_ff   <= 1'b0;
      wide_ff       <= 1'b0;
      op_ff         <= 3'b000;
      hi_keep_ff    <= 8'h00;
      memdst_ff     <= 1'b0;
    end else if (state_ff == lsr_pkg::ST_IDLE && start_req && (dec_logic || dec_shift)) begin
      work_ff       <= dec_logic ? logic_res : operand_ff;
      temp_ff       <= dec_logic ? 8'h00 : dec_count;
      cy_ff         <= flags_ff.carry;
      target_ff     <= dec_target;
      kind_logic_ff <= dec_logic;
      single_ff     <= dec_single;
      zero_cnt_ff   <= dec_shift & (dec_count == 8'h00);
      wide_ff       <= wide;
      op_ff         <= mid_f;
      hi_keep_ff    <= operand_ff[15:8];
      memdst_ff     <= dec_memdst;
    end else if (state_ff == lsr_pkg::ST_RUN && temp_ff != 8'h00) begin
      work_ff <= nxt_work;
      cy_ff   <= nxt_cy;
      temp_ff <= temp_ff - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // completion: result and flags
  // ----------------------------------------------------------------
  logic [15:0] fin_res;
  logic        fin_top;
  logic        fin_second;
  logic        fin_zero;
  logic        single_ovf;
  assign fin_res    = wide_ff ? work_ff : {hi_keep_ff, work_ff[7:0]};
  assign fin_top    = wide_ff ? work_ff[15] : work_ff[7];
  assign fin_second = wide_ff ? work_ff[14] : work_ff[6];
  assign fin_zero   = wide_ff ? (work_ff == 16'h0000) : (work_ff[7:0] == 8'h00);
  always_comb begin
    case (op_ff)
      lsr_pkg::OP_SHL, lsr_pkg::OP_ROL, lsr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_OP:
        single_ovf = fin_top ^ cy_ff;
      lsr_pkg::OP_ARITH_RIGHT_SHIFT_OP:
        single_ovf = 1'b0;
      default:
        single_ovf = fin_top ^ fin_second;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= lsr_pkg::RST_FLAGS;
    end else if (complete && !zero_cnt_ff) begin
      flags_ff.carry  <= cy_ff & ~kind_logic_ff;
      flags_ff.parity <= ~^work_ff[7:0];
      flags_ff.sign   <= fin_top;
      flags_ff.zero   <= fin_zero;
      if (single_ff || kind_logic_ff) begin
        flags_ff.ovf <= single_ovf & ~kind_logic_ff;
      end
    end else if (wr_en && paddr == lsr_pkg::OFS_FLAGS && state_ff == lsr_pkg::ST_IDLE) begin
      flags_ff <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff  <= lsr_pkg::RST_WORD;
      done_ff    <= 1'b0;
      illegal_ff <= 1'b0;
      memwb_ff   <= 1'b0;
      op_done_ff <= 1'b0;
    end else begin
      op_done_ff <= complete;
      if (complete) begin
        result_ff <= fin_res;
        memwb_ff  <= memdst_ff;
        done_ff   <= 1'b1;
      end else if (start_req && state_ff == lsr_pkg::ST_IDLE) begin
        done_ff    <= 1'b0;
        illegal_ff <= ~(dec_logic | dec_shift);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  acc_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_req && state_ff == lsr_pkg::ST_IDLE && dec_acc |-> ##6 op_done_ff)
    else $error("accumulator immediate form not done after 5 cycles");
  logic_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    complete && kind_logic_ff |=> !flags_ff.carry && !flags_ff.ovf &&
                                  flags_ff.aux == $past(flags_ff.aux))
    else $error("logical op left carry or overflow set");
  mem_imm_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    complete && kind_logic_ff && memdst_ff |->
      cnt_ff == lsr_pkg::CYC_LOGIC_MI ##1 memwb_ff)
    else $error("memory immediate logical took wrong time");
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == lsr_pkg::ST_RUN && temp_ff != 8'h00 && !complete |=>
      temp_ff == $past(temp_ff) - 8'h01)
    else $error("count copy did not decrement");
  zero_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    complete && zero_cnt_ff |=> flags_ff.carry == $past(flags_ff.carry) &&
                               result_ff == $past(fin_res))
    else $error("zero count changed carry or operand");
  counted_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_req && state_ff == lsr_pkg::ST_IDLE && dec_shift && !dec_single && !is_mem &&
    dec_count == 8'h03 |-> ##9 op_done_ff)
    else $error("counted register shift of three not done in 8 cycles");
  single_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    complete && single_ff |-> cnt_ff == (memdst_ff ? lsr_pkg::CYC_SHIFT1_MEM
                                                   : lsr_pkg::CYC_SHIFT1_REG))
    else $error("single bit step took wrong time");
  arith_right_shift_op_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    complete && single_ff && op_ff == lsr_pkg::OP_ARITH_RIGHT_SHIFT_OP |=> !flags_ff.ovf)
    else $error("arithmetic right shift left overflow set");
  arith_right_shift_op_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == lsr_pkg::ST_RUN && temp_ff != 8'h00 && op_ff == lsr_pkg::OP_ARITH_RIGHT_SHIFT_OP |=>
      (wide_ff ? work_ff[15] : work_ff[7]) == $past(wide_ff ? work_ff[15] : work_ff[7]))
    else $error("arithmetic right shift lost its top bit");
  counted_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    complete && !single_ff && !kind_logic_ff |=> flags_ff.ovf == $past(flags_ff.ovf))
    else $error("counted shift changed overflow");
endmodule // logic_shift_rotate_unit

// file: verification/apb_master_model.sv
// apb master model standing for the software side of the unit
`timescale 1ns/1ps
module apb_master_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ------
  // transfer
  // ------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // apb_master_model

// file: verification/tb_logic_shift_rotate_unit.sv
// testbench of the logic, shift and rotate unit
`timescale 1ns/1ps
module tb_logic_shift_rotate_unit;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, op_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #12.5 pclk = ~pclk;
  apb_master_model apb_master_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  logic_shift_rotate_unit logic_shift_rotate_unit_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_done(op_done));
  // ------
  // helpers
  // ------
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_master_model_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    apb_master_model_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (op_done !== 1'b1 && n < 400);
  endtask
  task automatic run(input logic [23:0] opc, input logic [15:0] opd, src,
                     input logic [7:0] cnt, input logic [5:0] fin,
                     input logic [15:0] er, input logic [5:0] ef, input int t);
    int n;
    wr(lsr_pkg::OFS_OPCODE, {8'h00, opc});
    wr(lsr_pkg::OFS_OPERAND, {16'h0000, opd});
    wr(lsr_pkg::OFS_SOURCE, {16'h0000, src});
    wr(lsr_pkg::OFS_COUNT, {24'h000000, cnt});
    wr(lsr_pkg::OFS_FLAGS, {26'h0, fin});
    wr(lsr_pkg::OFS_CTRL, 32'h1);
    wait_done(n);
    chk(n == t + 1, "cycle count");
    rd(lsr_pkg::OFS_RESULT);
    chk(q[15:0] === er, "result");
    rd(lsr_pkg::OFS_FLAGS);
    chk(q[5:0] === ef, "flags");
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_bus();
    rd(lsr_pkg::OFS_STATUS);
    chk(e === 1'b0 && q === 32'h0, "status reset");
    rd(8'h20);
    chk(e === 1'b1 && q === 32'h0, "unmapped");
  endtask
  task automatic t_logic();
    run(24'h000024,16'hABCD,16'h000F,8'h00,6'h21,16'hAB0D,6'h00,5);
    run(24'h000035,16'h1234,16'h00FF,8'h00,6'h21,16'h12CB,6'h00,5);
    run(24'h000881,16'h8000,16'h0001,8'h00,6'h21,16'h8001,6'h08,7);
    rd(lsr_pkg::OFS_STATUS);
    chk(q[lsr_pkg::STAT_MEMWB_BIT] === 1'b1, "memory writeback");
    chk(q[lsr_pkg::STAT_DONE_BIT] === 1'b1, "done flag");
    run(24'h00E080,16'h00F0,16'h000F,8'h00,6'h23,16'h0000,6'h16,5);
    run(24'h00F081,16'hFFFF,16'h7FFF,8'h00,6'h00,16'h8000,6'h0C,5);
    run(24'h00000B,16'h0F00,16'h00F0,8'h00,6'h21,16'h0FF0,6'h04,6);
  endtask
  task automatic t_shift();
    run(24'h00E0D1,16'h4001,16'h0000,8'h00,6'h00,16'h8002,6'h28,6);
    run(24'h0020D1,16'h4001,16'h0000,8'h00,6'h00,16'h8002,6'h28,8);
    run(24'h00E0D3,16'h6001,16'h0000,8'h03,6'h20,16'h0008,6'h21,8);
    run(24'h00E0D3,16'h1234,16'h0000,8'h00,6'h3F,16'h1234,6'h3F,5);
    run(24'h00E8D0,16'h1281,16'h0000,8'h00,6'h00,16'h1240,6'h21,6);
    run(24'h00E8D3,16'h0003,16'h0000,8'h01,6'h20,16'h0001,6'h21,6);
    run(24'h00F8D0,16'h0083,16'h0000,8'h00,6'h20,16'h00C1,6'h09,6);
    run(24'h02F8C1,16'h8004,16'h0000,8'h00,6'h20,16'hE001,6'h28,7);
  endtask
  task automatic t_rot();
    run(24'h00C0D1,16'h8001,16'h0000,8'h00,6'h00,16'h0003,6'h25,6);
    run(24'h00C8D1,16'h0001,16'h0000,8'h00,6'h00,16'h8000,6'h2D,6);
    run(24'h00C8D2,16'h001E,16'h0000,8'h04,6'h00,16'h00E1,6'h0D,9);
    run(24'h00D0D0,16'h0040,16'h0000,8'h00,6'h01,16'h0081,6'h2C,6);
    run(24'h02D0C1,16'hC000,16'h0000,8'h00,6'h00,16'h0001,6'h01,7);
    run(24'h00D8D1,16'h8001,16'h0000,8'h00,6'h01,16'hC000,6'h0D,6);
  endtask
  task automatic t_busy();
    int n;
    wr(lsr_pkg::OFS_OPCODE, 32'h0000E0D3);
    wr(lsr_pkg::OFS_OPERAND, 32'h1);
    wr(lsr_pkg::OFS_COUNT, 32'hC);
    wr(lsr_pkg::OFS_CTRL, 32'h1);
    wr(lsr_pkg::OFS_OPERAND, 32'h2);
    rd(lsr_pkg::OFS_STATUS);
    chk(q[lsr_pkg::STAT_BUSY_BIT] === 1'b1, "busy");
    wait_done(n);
    rd(lsr_pkg::OFS_RESULT);
    chk(q[15:0] === 16'h1000, "write while busy");
    wr(lsr_pkg::OFS_OPCODE, 32'h0000F0D1);
    wr(lsr_pkg::OFS_CTRL, 32'h1);
    n = 0;
    do begin
      rd(lsr_pkg::OFS_STATUS);
      n++;
    end while (q[lsr_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
    chk(q[lsr_pkg::STAT_ILLEGAL_BIT] === 1'b1, "illegal opcode");
  endtask
  // ------
  // run control
  // ------
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_logic();
    t_shift();
    t_rot();
    t_busy();
    complete_run();
  end
endmodule // tb_logic_shift_rotate_unit
